// >>> drw_pkg.sv
package drw_pkg;

  // ==========================================================
  // link geometry
  localparam int PAIRS = 16;
  localparam int BEATS = 16;
  localparam int REQ_W = 12;
  localparam logic [2:0] WIN0_PHASE = 3'h0;
  localparam logic [2:0] WIN1_PHASE = 3'h4;
  localparam logic [4:0] BEAT_LAST = 5'h16;
  localparam logic [4:0] BEAT_COUNT = 5'h10;
  localparam logic [1:0] CWD_LEFT_INIT = 2'h2;
  localparam logic [7:0] SINCE_IDLE = 8'hFF;

  // ==========================================================
  // spacing minimums (per speed bin where suffixed A/B/C) and banned cross-set distances, in master clock cycles
  localparam logic [7:0] WRITE_TO_PRECHARGE_GAP_A = 8'h0A;
  localparam logic [7:0] WRITE_TO_PRECHARGE_GAP_B = 8'h0C;
  localparam logic [7:0] WRITE_TO_PRECHARGE_GAP_C = 8'h0C;
  localparam logic [7:0] WDATA_TO_READ_GAP_A = 8'h06;
  localparam logic [7:0] WDATA_TO_READ_GAP_B = 8'h07;
  localparam logic [7:0] WDATA_TO_READ_GAP_C = 8'h07;
  localparam logic [7:0] WDATA_TO_PRECHARGE_GAP = 8'h09;
  localparam logic [7:0] REFRESH_LOAD_GAP_A = 8'h10;
  localparam logic [7:0] REFRESH_LOAD_GAP_B = 8'h14;
  localparam logic [7:0] REFRESH_LOAD_GAP_C = 8'h18;
  localparam logic [7:0] CROSS_SET_BAD_3 = 8'h03;
  localparam logic [7:0] CROSS_SET_BAD_5 = 8'h05;
  localparam logic [7:0] CROSS_SET_BAD_7 = 8'h07;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_COLUMN_WRITE = 4'h1,
    CMD_MASKED_COLUMN_WRITE = 4'h2,
    CMD_COLUMN_READ = 4'h3,
    CMD_PRECHARGE = 4'h4,
    CMD_REFRESH_ROW_LOAD_0 = 4'h5,
    CMD_REFRESH_ROW_LOAD_1 = 4'h6,
    CMD_REFRESH_ROW_LOAD_2 = 4'h7,
    CMD_ACTIVATE_REFRESH = 4'h8,
    CMD_INCREMENT_REFRESH = 4'h9,
    CMD_PRECHARGE_REFRESH = 4'hA
  } drw_cmd_e;

  // window 0 in the upper twelve bits
  typedef struct packed {
    drw_cmd_e cmd;
    logic [2:0] bank;
    logic [16:0] rest;
  } drw_req_s;

  typedef struct packed {
    logic [2:0] bank;
    logic [PAIRS-1:0][BEATS-1:0] data;
  } drw_word_s;

  typedef struct packed {
    logic writeToPrecharge;
    logic wdataToRead;
    logic wdataToPrecharge;
    logic refreshSpacing;
    logic crossSetRead;
  } drw_fault_s;

  function automatic logic [7:0] bin_pick(input logic [1:0] bin, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] c);
    bin_pick = (bin == 2'h0) ? a : ((bin == 2'h1) ? b : c);
  endfunction : bin_pick

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == SINCE_IDLE) ? v : v + 8'h01;
  endfunction : sat_inc

endpackage : drw_pkg

// >>> drw_pair_buf.sv
`timescale 1ns/10ps
// ==========================================================
// two-entry buffer, all outputs from flops
module drw_pair_buf import drw_pkg::*; #(
  parameter int W = 259
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);

  typedef struct packed {
    logic headV;
    logic secV;
    logic [W-1:0] head;
    logic [W-1:0] sec;
  } drw_buf_s;

  drw_buf_s b_r;
  drw_buf_s b_nxt;
  logic push;
  logic pop;

  assign inReady = ~b_r.secV;
  assign outValid = b_r.headV;
  assign outData = b_r.head;

  always_comb begin
    b_nxt = b_r;
    push = inValid & ~b_r.secV;
    pop = b_r.headV & outReady;
    if (pop) begin
      if (b_r.secV) begin
        b_nxt.head = b_r.sec;
        b_nxt.secV = 1'b0;
      end else begin
        b_nxt.head = inData;
        b_nxt.headV = push;
      end
    end else if (push) begin
      if (!b_r.headV) begin
        b_nxt.head = inData;
        b_nxt.headV = 1'b1;
      end else begin
        b_nxt.sec = inData;
        b_nxt.secV = 1'b1;
      end
    end
    if (!rst_n) begin
      b_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    b_r <= b_nxt;
  end

  a_full_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    b_r.secV |-> !inReady && outValid) else $error("full buffer still accepting");

endmodule : drw_pair_buf

// >>> drw_capture.sv
`timescale 1ns/10ps
// Summary of operation
// [R1] the controller leaves 10/12/12 cycles from a column write to a precharge of that bank.
// [R2] the controller leaves 6/7/7 cycles from write data start to a read of that bank.
// [R3] the controller leaves 9 cycles from write data to a precharge of that bank.
// [R4] refresh-row-load and refresh commands are spaced 16/20/24 cycles from each other; the monitor checks a refresh against the last load only.
// [R5] the spacing covers all three load variants and all three refresh variants alike.
// [R6] a cross-set read after a write never sits 3, 5 or 7 cycles after it.
// [R7] all sampling is referenced to the falling crossing of the true master clock leg.
// [R8] a low request line is a one and a high line a zero.
// [R9] each request line is sampled at the primary crossing and half a cycle later.
// [R10] sixteen data pairs, high true, a pair is one when its true leg is above its complement.
// [R11] each pair yields sixteen bits, bit j taken j eighths after its offset point.
// [R12] each pair has a static offset taken once at initialisation.
// [R13] bits are packed in window order, window 0 in bit 0, before the word is handed on.
module drw_capture import drw_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic masterClockTrue,
  input wire logic masterClockComp,
  input wire logic [REQ_W-1:0] requestLines,
  input wire logic [PAIRS-1:0] dataPairTrue,
  input wire logic [PAIRS-1:0] dataPairComp,
  input wire logic [PAIRS-1:0][2:0] perPairReceiveOffset,
  input wire logic [1:0] speedBin,
  output logic wordValid,
  input wire logic wordReady,
  output drw_word_s wordOut,
  output drw_fault_s spacingFault,
  output logic overrun
);

  // ==========================================================
  // link domain: linkClk is an eighth-cycle beat clock
  typedef struct packed {
    logic [1:0] rstSync;
    logic initDone;
    logic clkPrev;
    logic [2:0] phase;
    logic [REQ_W-1:0] win0;
    logic reqValid;
    drw_req_s reqPkt;
    logic [1:0] bin;
    logic [PAIRS-1:0][2:0] offsets;
    logic [7:0] sinceWrite;
    logic [7:0] sinceWdata;
    logic [7:0] sinceLoad;
    logic [7:0] sinceRefresh;
    logic [2:0] writeBank;
    logic cwdArmed;
    logic [1:0] cwdLeft;
    logic burstOn;
    logic [4:0] beatCnt;
    logic [2:0] burstBank;
    logic [PAIRS-1:0][BEATS-1:0] word;
    drw_word_s hold;
    logic xferTgl;
    drw_fault_s faults;
  } drw_link_s;

  drw_link_s lk_r;
  drw_link_s lk_nxt;
  logic clkNow;
  logic primary;
  logic [2:0] ph;
  logic startNow;
  logic active;
  logic [4:0] beat;
  logic [4:0] slot;
  logic [PAIRS-1:0] dataBit;
  logic isLoad;
  logic isRefresh;
  logic [7:0] loadGap;

  always_comb begin
    lk_nxt = lk_r;
    clkNow = masterClockTrue & ~masterClockComp;
    primary = lk_r.clkPrev & ~clkNow; // see [R7]
    ph = primary ? WIN0_PHASE : lk_r.phase + 3'h1;
    dataBit = dataPairTrue & ~dataPairComp; // see [R10]
    startNow = 1'b0;
    slot = 5'h00;
    isLoad = 1'b0;
    isRefresh = 1'b0;
    loadGap = bin_pick(lk_r.bin, REFRESH_LOAD_GAP_A, REFRESH_LOAD_GAP_B, REFRESH_LOAD_GAP_C);
    lk_nxt.rstSync = {lk_r.rstSync[0], rst_n};
    lk_nxt.clkPrev = clkNow;
    lk_nxt.phase = ph;
    lk_nxt.reqValid = 1'b0;
    // straps caught once, after reset release
    if (!lk_r.initDone) begin
      lk_nxt.bin = speedBin;
      lk_nxt.offsets = perPairReceiveOffset; // see [R12]
      lk_nxt.initDone = 1'b1;
    end
    if (ph == WIN0_PHASE) begin
      lk_nxt.win0 = ~requestLines; // see [R8] [R9]
    end
    if (ph == WIN1_PHASE) begin
      lk_nxt.reqPkt = drw_req_s'({lk_r.win0, ~requestLines}); // see [R8] [R9]
      lk_nxt.reqValid = 1'b1;
    end
    // one tick per master cycle at the primary crossing
    if (ph == WIN0_PHASE) begin
      lk_nxt.sinceWrite = sat_inc(lk_r.sinceWrite);
      lk_nxt.sinceWdata = sat_inc(lk_r.sinceWdata);
      lk_nxt.sinceLoad = sat_inc(lk_r.sinceLoad);
      lk_nxt.sinceRefresh = sat_inc(lk_r.sinceRefresh);
      if (lk_r.cwdArmed) begin
        if (lk_r.cwdLeft == 2'h0) begin
          startNow = 1'b1;
          lk_nxt.cwdArmed = 1'b0;
          lk_nxt.sinceWdata = 8'h00;
          lk_nxt.burstBank = lk_r.writeBank;
          lk_nxt.word = '0;
        end else begin
          lk_nxt.cwdLeft = lk_r.cwdLeft - 2'h1;
        end
      end
    end
    // a new burst restarts one still in flight; writes closer than three cycles lose data
    active = startNow | lk_r.burstOn;
    beat = startNow ? 5'h00 : lk_r.beatCnt + 5'h01;
    if (active) begin
      for (int i = 0; i < PAIRS; i++) begin
        slot = beat - {2'b00, lk_r.offsets[i]};
        if (beat >= {2'b00, lk_r.offsets[i]} && slot < BEAT_COUNT) begin
          lk_nxt.word[i][slot[3:0]] = dataBit[i]; // see [R11] [R13]
        end
      end
      lk_nxt.beatCnt = beat;
      lk_nxt.burstOn = (beat != BEAT_LAST);
      if (beat == BEAT_LAST) begin
        lk_nxt.hold = {lk_nxt.burstBank, lk_nxt.word}; // see [R13]
        lk_nxt.xferTgl = ~lk_r.xferTgl;
      end
    end
    // spacing monitor on the decoded request
    if (lk_r.reqValid) begin
      isLoad = lk_r.reqPkt.cmd inside {CMD_REFRESH_ROW_LOAD_0, CMD_REFRESH_ROW_LOAD_1,
                                       CMD_REFRESH_ROW_LOAD_2}; // see [R5]
      isRefresh = lk_r.reqPkt.cmd inside {CMD_ACTIVATE_REFRESH, CMD_INCREMENT_REFRESH,
                                          CMD_PRECHARGE_REFRESH}; // see [R5]
      unique case (lk_r.reqPkt.cmd)
        CMD_COLUMN_WRITE, CMD_MASKED_COLUMN_WRITE: begin
          lk_nxt.sinceWrite = 8'h00;
          lk_nxt.writeBank = lk_r.reqPkt.bank;
          lk_nxt.cwdArmed = 1'b1;
          lk_nxt.cwdLeft = CWD_LEFT_INIT;
        end
        CMD_COLUMN_READ: begin
          if (lk_r.reqPkt.bank == lk_r.writeBank && lk_r.sinceWdata < bin_pick(lk_r.bin,
              WDATA_TO_READ_GAP_A, WDATA_TO_READ_GAP_B, WDATA_TO_READ_GAP_C)) begin
            lk_nxt.faults.wdataToRead = 1'b1; // see [R2]
          end
          if (lk_r.reqPkt.bank[2] != lk_r.writeBank[2] && lk_r.sinceWrite inside
              {CROSS_SET_BAD_3, CROSS_SET_BAD_5, CROSS_SET_BAD_7}) begin
            lk_nxt.faults.crossSetRead = 1'b1; // see [R6]
          end
        end
        CMD_PRECHARGE: begin
          if (lk_r.reqPkt.bank == lk_r.writeBank) begin
            if (lk_r.sinceWrite < bin_pick(lk_r.bin, WRITE_TO_PRECHARGE_GAP_A,
                WRITE_TO_PRECHARGE_GAP_B, WRITE_TO_PRECHARGE_GAP_C)) begin
              lk_nxt.faults.writeToPrecharge = 1'b1; // see [R1]
            end
            if (lk_r.sinceWdata < WDATA_TO_PRECHARGE_GAP) begin
              lk_nxt.faults.wdataToPrecharge = 1'b1; // see [R3]
            end
          end
        end
        default: begin
        end
      endcase
      if (isLoad || isRefresh) begin
        if (lk_r.sinceLoad < loadGap || (isLoad && lk_r.sinceRefresh < loadGap)) begin
          lk_nxt.faults.refreshSpacing = 1'b1; // see [R4]
        end
        if (isLoad) begin
          lk_nxt.sinceLoad = 8'h00;
        end else begin
          lk_nxt.sinceRefresh = 8'h00;
        end
      end
    end
    if (!lk_r.rstSync[1]) begin
      lk_nxt = '0;
      lk_nxt.rstSync = {lk_r.rstSync[0], rst_n};
      lk_nxt.sinceWrite = SINCE_IDLE;
      lk_nxt.sinceWdata = SINCE_IDLE;
      lk_nxt.sinceLoad = SINCE_IDLE;
      lk_nxt.sinceRefresh = SINCE_IDLE;
    end
  end

  always_ff @(posedge linkClk) begin
    lk_r <= lk_nxt;
  end

  // ==========================================================
  // system domain: word hand-off and fault synchronisers
  typedef struct packed {
    logic [2:0] tgl;
    drw_fault_s f0;
    drw_fault_s f1;
    logic pendV;
    drw_word_s pend;
    logic overrun;
  } drw_sys_s;

  drw_sys_s sy_r;
  drw_sys_s sy_nxt;
  logic bufInReady;

  always_comb begin
    sy_nxt = sy_r;
    sy_nxt.tgl = {sy_r.tgl[1], sy_r.tgl[0], lk_r.xferTgl};
    sy_nxt.f0 = lk_r.faults;
    sy_nxt.f1 = sy_r.f0;
    if (sy_r.pendV && bufInReady) begin
      sy_nxt.pendV = 1'b0;
    end
    // hold stays stable for many beats after its toggle is seen here
    if (sy_r.tgl[2] ^ sy_r.tgl[1]) begin
      if (sy_nxt.pendV) begin
        sy_nxt.overrun = 1'b1;
      end
      sy_nxt.pendV = 1'b1;
      sy_nxt.pend = lk_r.hold;
    end
    if (!rst_n) begin
      sy_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    sy_r <= sy_nxt;
  end

  drw_pair_buf #(.W($bits(drw_word_s))) wordBuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(sy_r.pendV),
    .inReady(bufInReady),
    .inData(sy_r.pend),
    .outValid(wordValid),
    .outReady(wordReady),
    .outData(wordOut)
  );

  assign spacingFault = sy_r.f1;
  assign overrun = sy_r.overrun;

  // ==========================================================
  // checks
  sequence s_burst_end;
    lk_r.burstOn ##1 !lk_r.burstOn;
  endsequence

  a_primary_phase: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    (lk_r.clkPrev && !(masterClockTrue && !masterClockComp)) |=> lk_r.phase == WIN0_PHASE)
    else $error("phase not aligned to primary crossing"); // see [R7]
  a_req_inverted: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    lk_r.reqValid |-> lk_r.reqPkt[REQ_W-1:0] == ~$past(requestLines))
    else $error("request polarity wrong"); // see [R8]
  a_req_window: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    lk_r.reqValid |-> lk_r.phase == WIN1_PHASE && $past(lk_r.phase, 4) == WIN0_PHASE)
    else $error("request window misplaced"); // see [R9]
  a_pair0_bit: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    (lk_r.burstOn && lk_r.beatCnt == {2'b00, lk_r.offsets[0]} - 5'h01)
    |=> lk_r.word[0][0] == $past(dataPairTrue[0] && !dataPairComp[0]))
    else $error("pair 0 window 0 not captured"); // see [R10] [R11]
  a_burst_length: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    s_burst_end |-> lk_r.beatCnt == BEAT_LAST && lk_r.xferTgl != $past(lk_r.xferTgl))
    else $error("burst length or hand-off wrong"); // see [R11] [R13]
  a_offset_static: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    $past(lk_r.initDone) |-> $stable(lk_r.offsets))
    else $error("pair offset changed"); // see [R12]
  a_refresh_group: assert property (@(posedge linkClk) disable iff (!lk_r.rstSync[1])
    (lk_r.reqValid && lk_r.reqPkt.cmd == CMD_PRECHARGE_REFRESH) |=> lk_r.sinceRefresh == 8'h00)
    else $error("refresh variant not tracked"); // see [R5]
  a_fault_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    (|$past(spacingFault) && $past(rst_n)) |-> (spacingFault & $past(spacingFault))
    == $past(spacingFault)) else $error("spacing fault cleared"); // see [R4]
  a_handoff_lat: assert property (@(posedge mclk) disable iff (!rst_n)
    (sy_r.tgl[2] != sy_r.tgl[1]) |=> sy_r.pendV && sy_r.pend == $past(lk_r.hold))
    else $error("word not taken on toggle"); // see [R13]

endmodule : drw_capture

// >>> drw_ctl_model.sv
`timescale 1ns/10ps
// ==========
// controller model: beat clock drives eight beats per master cycle
module drw_ctl_model import drw_pkg::*; (
  input wire logic linkClk,
  input wire logic [PAIRS-1:0][2:0] offs,
  output logic masterClockTrue,
  output logic masterClockComp,
  output logic [REQ_W-1:0] requestLines,
  output logic [PAIRS-1:0] dataPairTrue,
  output logic [PAIRS-1:0] dataPairComp
);
  typedef struct packed {
    logic [3:0] cmd;
    logic [2:0] bank;
    logic [7:0] gap;
    logic [PAIRS-1:0][BEATS-1:0] data;
  } drw_cmd_s;

  drw_cmd_s q[$];
  drw_cmd_s cur;
  logic [PAIRS-1:0][BEATS-1:0] burst;
  logic [2:0] nb;
  logic [23:0] pkt = 24'h0;
  int tick = 0;
  int since = 255;
  int start = -100;
  int b;

  // gap counts master cycles after the previous command
  task automatic send(input logic [3:0] cmd, input logic [2:0] bank, input logic [7:0] gap,
                      input logic [PAIRS-1:0][BEATS-1:0] data);
    drw_cmd_s c;
    c = '{cmd, bank, gap, data};
    q.push_back(c);
  endtask : send

  initial begin
    masterClockTrue = 1'b1;
    masterClockComp = 1'b0;
    requestLines = '1;
    dataPairTrue = '1;
    dataPairComp = '1;
  end

  always @(posedge linkClk) begin
    nb = 3'(tick + 1);
    masterClockTrue <= nb[2];
    masterClockComp <= ~nb[2];
    if (nb == 3'h0) begin
      since = since + 1;
      pkt = 24'h0;
      if (q.size() > 0 && since >= int'(q[0].gap)) begin
        cur = q.pop_front();
        pkt = {cur.cmd, cur.bank, 17'h0};
        since = 0;
        if (cur.cmd == 4'h1 || cur.cmd == 4'h2) begin
          burst = cur.data;
          start = tick + 25;  // data opens at third primary crossing after window 1
        end
      end
    end
    requestLines <= (nb < 3'h4) ? ~pkt[23:12] : ~pkt[11:0];
    b = tick + 1 - start;
    for (int i = 0; i < PAIRS; i++) begin
      if (b - int'(offs[i]) >= 0 && b - int'(offs[i]) < BEATS) begin
        dataPairTrue[i] <= burst[i][b - int'(offs[i])];
        dataPairComp[i] <= ~burst[i][b - int'(offs[i])];
      end else begin
        // undriven pairs settle at the termination level, 1/1
        dataPairTrue[i] <= 1'b1;
        dataPairComp[i] <= 1'b1;
      end
    end
    tick = tick + 1;
  end
endmodule : drw_ctl_model

// >>> drw_capture_tb.sv
`timescale 1ns/10ps
module drw_capture_tb import drw_pkg::*;;
  localparam int WATCH_NS = 300000;
  localparam logic [3:0] GRP [7] = '{4'h5, 4'h6, 4'h8, 4'h7, 4'h9, 4'hA, 4'h5};
  logic mclk, linkClk, rst_n, wordValid, overrun, stall;
  logic wordReady = 1'b0;
  logic [1:0] speedBin;
  logic masterClockTrue, masterClockComp;
  logic [REQ_W-1:0] requestLines;
  logic [PAIRS-1:0] dataPairTrue, dataPairComp;
  logic [PAIRS-1:0][2:0] offs;
  drw_word_s wordOut;
  drw_word_s expQ[$];
  drw_fault_s spacingFault, ef;
  logic [31:0] seed = 32'hE31D;
  logic [31:0] rdySeed = 32'hE31D;
  int failures = 0;
  int n_checks = 0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #3.3;
    forever #6 linkClk = ~linkClk;
  end

  drw_capture DUT (.mclk(mclk), .rst_n(rst_n), .linkClk(linkClk),
    .masterClockTrue(masterClockTrue), .masterClockComp(masterClockComp),
    .requestLines(requestLines), .dataPairTrue(dataPairTrue), .dataPairComp(dataPairComp),
    .perPairReceiveOffset(offs), .speedBin(speedBin), .wordValid(wordValid),
    .wordReady(wordReady), .wordOut(wordOut), .spacingFault(spacingFault), .overrun(overrun));
  drw_ctl_model ctl (.linkClk(linkClk), .offs(offs), .masterClockTrue(masterClockTrue),
    .masterClockComp(masterClockComp), .requestLines(requestLines),
    .dataPairTrue(dataPairTrue), .dataPairComp(dataPairComp));

  task automatic check(input logic [258:0] got, input logic [258:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // keep marks a word that must come out; a replaced one is not noted
  task automatic wr(input logic [3:0] cmd, input logic [2:0] bank, input logic [7:0] gap,
                    input bit keep);
    drw_word_s w;
    logic [255:0] d;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      d[k*32 +: 32] = seed;
    end
    w.bank = bank;
    w.data = d;
    if (keep) expQ.push_back(w);
    ctl.send(cmd, bank, gap, w.data);
  endtask : wr

  task automatic settle;
    for (int t = 0; t < 20000 && ctl.q.size() > 0; t++) @(posedge mclk);
    repeat (100) @(posedge mclk);
  endtask : settle

  // ==========
  // word monitor; the sink stalls at random
  always @(posedge mclk) begin
    if (rst_n === 1'b1 && wordValid === 1'b1 && wordReady === 1'b1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("MISMATCH at %0t ns: got %h expected %h", $time, wordOut, 259'h0);
      end else begin
        check(wordOut, expQ.pop_front());
      end
    end
    rdySeed = lfsr(rdySeed);
    wordReady <= ~stall & rdySeed[5];
  end

  initial begin
    #WATCH_NS;
    failures++;
    test_done;
  end

  // ==========
  // main sequence, speed bin A, then bin B after a mid-run reset
  initial begin
    rst_n = 1'b0;
    stall = 1'b1;
    speedBin = 2'h0;
    ef = '0;
    for (int i = 0; i < PAIRS; i++) begin
      seed = lfsr(seed);
      offs[i] = seed[2:0];
    end
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check(wordValid, 1'b0);
    stall <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      wr((k % 2 == 1) ? 4'h2 : 4'h1, seed[2:0], 8'h06, 1'b1);
    end
    wr(4'h1, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h3, 3'h0, 8'h09, '0);
    ctl.send(4'h4, 3'h0, 8'h03, '0);
    wr(4'h2, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h3, 3'h4, 8'h04, '0);
    for (int k = 0; k < 7; k++) ctl.send(GRP[k], 3'h0, 8'h10, '0);
    settle;
    check(spacingFault, ef);
    wr(4'h1, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h4, 3'h0, 8'h0B, '0);
    settle;
    ef.wdataToPrecharge = 1'b1;
    check(spacingFault, ef);
    wr(4'h2, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h4, 3'h0, 8'h09, '0);
    settle;
    ef.writeToPrecharge = 1'b1;
    check(spacingFault, ef);
    wr(4'h1, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h3, 3'h0, 8'h08, '0);
    settle;
    ef.wdataToRead = 1'b1;
    check(spacingFault, ef);
    wr(4'h1, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h3, 3'h4, 8'h03, '0);
    settle;
    ef.crossSetRead = 1'b1;
    check(spacingFault, ef);
    ctl.send(4'h6, 3'h0, 8'h06, '0);
    ctl.send(4'hA, 3'h0, 8'h0F, '0);
    settle;
    ef.refreshSpacing = 1'b1;
    check(spacingFault, ef);
    check(overrun, 1'b0);
    // stalled sink: two buffered, third pending, fourth replaces it
    stall <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(4'h1, seed[2:0], 8'h06, k != 2);
    end
    settle;
    check(overrun, 1'b1);
    check(wordValid, 1'b1);
    stall <= 1'b0;
    for (int t = 0; t < 2000 && expQ.size() > 0; t++) @(posedge mclk);
    check(32'(expQ.size()), 32'h0);
    // mid-run reset into speed bin B; the straps are caught again on release
    rst_n <= 1'b0;
    speedBin <= 2'h1;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    ef = '0;
    check(spacingFault, ef);
    check(overrun, 1'b0);
    // gaps that bin A accepts are short in bin B
    wr(4'h1, 3'h0, 8'h06, 1'b1);
    ctl.send(4'h3, 3'h0, 8'h09, '0);
    ctl.send(4'h5, 3'h0, 8'h06, '0);
    ctl.send(4'h7, 3'h0, 8'h10, '0);
    settle;
    ef.wdataToRead = 1'b1;
    ef.refreshSpacing = 1'b1;
    check(spacingFault, ef);
    for (int t = 0; t < 2000 && expQ.size() > 0; t++) @(posedge mclk);
    check(32'(expQ.size()), 32'h0);
    test_done;
  end
endmodule : drw_capture_tb
